// *** common/cmpctl_pkg.sv ***
/*
  cmpctl_pkg: register map, field positions, reset values and carriers
  for the comparator control block.
  assumes: 8-bit registers in the low byte of a 32-bit wishbone word.
*/
`default_nettype none
package cmpctl_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMP_CS   = 8'h30;
  localparam logic [7:0] ADDR_CONV_CSB = 8'h34;
  localparam logic [7:0] ADDR_DIG_DIS  = 8'h38;
  localparam logic [7:0] ADDR_CONV_CSA = 8'h3c;
  localparam logic [7:0] ADDR_CONV_CH  = 8'h40;
  localparam int         ADDR_W        = 8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_POWER_OFF   = 7;
  localparam int POS_BANDGAP     = 6;
  localparam int POS_RESULT      = 5;
  localparam int POS_IRQ_FLAG    = 4;
  localparam int POS_IRQ_ENABLE  = 3;
  localparam int POS_CAPTURE     = 2;
  localparam int POS_MODE_HI     = 1;
  localparam int POS_MODE_LO     = 0;
  localparam int POS_MUX_ENABLE  = 6;
  localparam int POS_NEG_BUF_OFF = 1;
  localparam int POS_POS_BUF_OFF = 0;
  localparam int POS_CONV_ENABLE = 7;
  localparam int CHAN_W          = 3;

  // ----------------------------------------------------------------
  // reset values and interrupt modes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h0;

  typedef enum logic [1:0] {
    CMPCT_MODE_TOGGLE   = 2'b00,
    CMPCT_MODE_RESERVED = 2'b01,
    CMPCT_MODE_FALL     = 2'b10,
    CMPCT_MODE_RISE     = 2'b11
  } cmpct_mode_t;

  // software-owned comparator controls
  typedef struct packed {
    logic        power_off;
    logic        bandgap_positive_select;
    logic        cmp_irq_enable;
    logic        cmp_capture_route;
    cmpct_mode_t mode;
  } cmpct_ctrl_t;

  // converter side controls that steer the negative input, plus the two pin buffer-off bits
  typedef struct packed {
    logic              neg_input_mux_enable;
    logic              converter_enable;
    logic [CHAN_W-1:0] channel_select;
    logic              negative_pin_buffer_off;
    logic              positive_pin_buffer_off;
  } cmpct_conv_t;
endpackage : cmpctl_pkg
`default_nettype wire

// *** sim/cmpctl_analog_model.sv ***
/*
  cmpctl_analog_model: analog sources and timer capture front end.
  assumes: levels are commanded by the bench on clk_i.
*/
`default_nettype none
module cmpctl_analog_model (
  input  wire logic        clk_i,
  input  wire logic [9:0]  pos_lvl_i,
  input  wire logic [9:0]  neg_lvl_i,
  input  wire logic [79:0] chan_lvl_i,
  input  wire logic        capture_input_i,
  output logic      [9:0]  positive_pin_o,
  output logic      [9:0]  negative_pin_o,
  output logic      [79:0] converter_input_pins_o,
  output logic      [15:0] capture_rises_o
);
  logic cap_ff;
  initial begin
    positive_pin_o = 10'h0;
    negative_pin_o = 10'h3ff;
    converter_input_pins_o = '1;
    capture_rises_o = 16'h0;
    cap_ff = 1'b0;
  end
  // sources settle a cycle late; capture counts rising edges only
  always @(posedge clk_i) begin
    positive_pin_o <= pos_lvl_i;
    negative_pin_o <= neg_lvl_i;
    converter_input_pins_o <= chan_lvl_i;
    cap_ff <= capture_input_i;
    if (capture_input_i && !cap_ff) capture_rises_o <= capture_rises_o + 16'h1;
  end
endmodule : cmpctl_analog_model
`default_nettype wire

// *** sim/cmpctl_monitor.sv ***
/*
  cmpctl_monitor: port-level assertions for cmpctl_top.
  assumes: bound into cmpctl_top, one clock, sync reset.
*/
`default_nettype none
module cmpctl_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        global_irq_enable_i,
  input wire logic        cmp_irq_req_o,
  input wire logic        capture_input_o,
  input wire logic        cmp_power_off_o,
  input wire logic [1:0]  pin_buffer_off_o,
  input wire logic [1:0]  pin_read_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // write strobes at the edge where a write lands
  logic wr_ok, wr_cs, wr_dd;
  assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign wr_cs = wr_ok && wb_adr_i == cmpctl_pkg::ADDR_CMP_CS;
  assign wr_dd = wr_ok && wb_adr_i == cmpctl_pkg::ADDR_DIG_DIS;
  // shadow enables, since registers are hidden from us
  logic route_ff, ena_ff, nxt_route, nxt_ena;
  always_comb begin
    nxt_route = wr_cs ? wb_dat_i[2] : route_ff;
    nxt_ena   = wr_cs ? wb_dat_i[3] : ena_ff;
  end
  always_ff @(posedge clk_i) begin
    route_ff <= rst_i ? 1'b0 : nxt_route;
    ena_ff   <= rst_i ? 1'b0 : nxt_ena;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_wait_a : assert property (s_req |=> s_ack)
    else $error("bus request not answered in one cycle");
  ack_idle_a : assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("ack without a request");
  dat_high_a : assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  power_bit_a : assert property (wr_cs |=> cmp_power_off_o == $past(wb_dat_i[7]))
    else $error("power-off output does not follow write");
  power_quiet_a : assert property (cmp_power_off_o [*4] |-> !capture_input_o)
    else $error("capture active while powered off");
  buf_bits_a : assert property (wr_dd |=> pin_buffer_off_o == $past(wb_dat_i[1:0]))
    else $error("buffer-off outputs do not follow write");
  pin_mask_a : assert property ((pin_buffer_off_o & pin_read_o) == 2'h0)
    else $error("pin read high while buffer off");
  route_gate_a : assert property (capture_input_o |-> route_ff || $past(route_ff))
    else $error("capture input without route");
  irq_gate_a : assert property (cmp_irq_req_o |->
    $past(global_irq_enable_i) && (ena_ff || $past(ena_ff)))
    else $error("irq request without enables");
endmodule : cmpctl_monitor
bind cmpctl_top cmpctl_monitor cmpctl_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .global_irq_enable_i(global_irq_enable_i), .cmp_irq_req_o(cmp_irq_req_o),
  .capture_input_o(capture_input_o), .cmp_power_off_o(cmp_power_off_o),
  .pin_buffer_off_o(pin_buffer_off_o), .pin_read_o(pin_read_o));
`default_nettype wire

// *** sim/test_comparator_control_logic.sv ***
/*
  test_comparator_control_logic: self-checking bench for cmpctl_top.
  assumes: cmpctl_monitor bound in; analog model on the far side.
*/
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module test_comparator_control_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, gie = 1'b0, vec = 1'b0;
  logic [7:0]  adr = 8'h0, md;
  logic [3:0]  sl = 4'h0, sel_w = 4'h1;
  logic [31:0] wd = 32'h0, rdat, dat_o;
  logic [9:0]  pl = 10'h0, nl = 10'h3ff, pp, np;
  logic [79:0] cl = '1, ct, cp;
  logic [1:0]  pdig = 2'h0, bof, prd;
  logic [15:0] rises, c0;
  logic        ack, cmp_irq, cap, pwr;
  int          errors = 0, comparisons = 0, n;
  // address table with the bits each place reads back as written
  logic [7:0]  adrs [6] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44};
  logic [7:0]  msk [6] = '{8'hcf, 8'h40, 8'h03, 8'h80, 8'h07, 8'h00};
  always #2 clk_i = ~clk_i;
  cmpctl_analog_model cmpctl_analog_model_i (.clk_i(clk_i), .pos_lvl_i(pl), .neg_lvl_i(nl),
    .chan_lvl_i(cl), .capture_input_i(cap), .positive_pin_o(pp), .negative_pin_o(np),
    .converter_input_pins_o(cp), .capture_rises_o(rises));
  cmpctl_top #(.LEVEL_W(10), .NUM_CHAN(8), .BANDGAP_LEVEL(16'h0100)) cmpctl_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sl), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .positive_pin_i(pp), .negative_pin_i(np), .converter_input_pins_i(cp),
    .pin_digital_i(pdig), .global_irq_enable_i(gie), .irq_vector_taken_i(vec),
    .cmp_irq_req_o(cmp_irq), .capture_input_o(cap), .cmp_power_off_o(pwr),
    .pin_buffer_off_o(bof), .pin_read_o(prd));
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick
  // one classic cycle; the wait is bounded so a dead slave ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= w;
    sl <= sel_w;
    adr <= a;
    wd <= {24'h0, d};
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin errors++; results(); end
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    sl <= 4'h0;
    @(posedge clk_i);
  endtask : bus
  // does mode m flag a rising (r) or falling edge
  function automatic logic ev(input logic [1:0] m, input logic r);
    return m == 2'b00 || (m == 2'b11 && r) || (m == 2'b10 && !r);
  endfunction : ev
  initial begin
    n = $urandom(32'h8e45ccb3);
    tick(6);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, adrs[i], 8'h0);
      `CHK(rdat, 32'h0)
      repeat (3) begin
        md = 8'($urandom);
        bus(1'b1, adrs[i], md);
        bus(1'b0, adrs[i], 8'h0);
        `CHK(rdat, {24'h0, md & msk[i]})
      end
      bus(1'b1, adrs[i], 8'h0);
    end
    // a write with lane 0 unselected must leave the register alone
    sel_w = 4'h0;
    bus(1'b1, 8'h34, 8'h40);
    sel_w = 4'h1;
    bus(1'b0, 8'h34, 8'h0);
    `CHK(rdat, 32'h0)
    nl <= 10'h0;
    for (int m = 0; m < 4; m++) begin
      md = 8'(m);
      gie <= 1'b1;
      bus(1'b1, 8'h30, 8'h10 | md);
      bus(1'b1, 8'h30, 8'h08 | md);
      pl <= 10'h3ff;
      tick(5);
      bus(1'b0, 8'h30, 8'h0);
      `CHK(rdat[5:4], {1'b1, ev(md[1:0], 1'b1)})
      `CHK(cmp_irq, ev(md[1:0], 1'b1))
      bus(1'b1, 8'h30, 8'h08 | md);
      `CHK(cmp_irq, ev(md[1:0], 1'b1))
      vec <= 1'b1;
      @(posedge clk_i);
      vec <= 1'b0;
      tick(2);
      `CHK(cmp_irq, 1'b0)
      gie <= md[1];
      pl <= 10'h0;
      tick(5);
      bus(1'b0, 8'h30, 8'h0);
      `CHK(rdat[5:4], {1'b0, ev(md[1:0], 1'b0)})
      `CHK(cmp_irq, ev(md[1:0], 1'b0) & md[1])
      bus(1'b1, 8'h30, 8'h10 | md);
      bus(1'b0, 8'h30, 8'h0);
      `CHK(rdat[4], 1'b0)
    end
    // channel levels straddle the positive level, equal on channel 0
    for (int k = 0; k < 8; k++) ct[k*10 +: 10] = k == 0 ? 10'h200 : k == 7 ? 10'h1ff : 10'($urandom);
    cl <= ct;
    pl <= 10'h200;
    nl <= 10'h3ff;
    bus(1'b1, 8'h30, 8'h00);
    bus(1'b1, 8'h34, 8'h40);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 8'h40, 8'(k));
      tick(3);
      bus(1'b0, 8'h30, 8'h0);
      `CHK(rdat[5], pl > ct[k*10 +: 10])
    end
    bus(1'b1, 8'h3c, 8'h80);
    tick(3);
    bus(1'b0, 8'h30, 8'h0);
    `CHK(rdat[5], 1'b0)
    bus(1'b1, 8'h3c, 8'h00);
    bus(1'b1, 8'h34, 8'h00);
    tick(3);
    bus(1'b0, 8'h30, 8'h0);
    `CHK(rdat[5], 1'b0)
    pl <= 10'h0;
    nl <= 10'h0ff;
    bus(1'b1, 8'h30, 8'h40);
    tick(3);
    bus(1'b0, 8'h30, 8'h0);
    `CHK(rdat[5], 1'b1)
    nl <= 10'h100;
    tick(4);
    bus(1'b0, 8'h30, 8'h0);
    `CHK(rdat[5], 1'b0)
    pl <= 10'h3ff;
    nl <= 10'h0;
    // capture route stays on while powered off, so the quiet check bites
    bus(1'b1, 8'h30, 8'h84);
    tick(4);
    bus(1'b0, 8'h30, 8'h0);
    `CHK(rdat[5], 1'b0)
    `CHK(pwr, 1'b1)
    c0 = rises;
    bus(1'b1, 8'h30, 8'h04);
    tick(5);
    `CHK(cap, 1'b1)
    `CHK(pwr, 1'b0)
    for (int r = 0; r < 4; r++) begin
      pl <= r[0] ? 10'h3ff : 10'h0;
      tick(5);
      if (r == 1) bus(1'b1, 8'h30, 8'h00);
    end
    `CHK(cap, 1'b0)
    `CHK(rises, c0 + 16'h2)
    pdig <= 2'h3;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'h38, 8'(k));
      tick(3);
      `CHK(prd, 2'h3 & ~2'(k))
      `CHK(bof, 2'(k))
    end
    results();
  end
endmodule : test_comparator_control_logic
`default_nettype wire

// *** verilog/cmpctl_top.sv ***
/*
  cmpctl_top: digital control around the on-chip voltage comparator,
  with a classic wishbone register slave.
  assumes: analog levels arrive as unsigned codes from outside the
  clock domain; the interrupt controller gives a global enable and a
  vector-taken pulse on clk_i.
*/
`default_nettype none
module cmpctl_top #(
  parameter int          LEVEL_W       = 10,
  parameter int          NUM_CHAN      = 8,
  parameter logic [15:0] BANDGAP_LEVEL = 16'h0100
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [LEVEL_W-1:0]      positive_pin_i,
  input  wire logic [LEVEL_W-1:0]      negative_pin_i,
  input  wire logic [NUM_CHAN*LEVEL_W-1:0] converter_input_pins_i,
  input  wire logic [1:0]              pin_digital_i,
  input  wire logic                    global_irq_enable_i,
  input  wire logic                    irq_vector_taken_i,
  output logic                         cmp_irq_req_o,
  output logic                         capture_input_o,
  output logic                         cmp_power_off_o,
  output logic [1:0]                   pin_buffer_off_o,
  output logic [1:0]                   pin_read_o
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // channel select is fixed at three bits, so eight inputs exactly
  if (NUM_CHAN != 8) begin : g_chan_chk
    $error("cmpctl_top: NUM_CHAN must be 8");
  end
  if (LEVEL_W < 1 || LEVEL_W > 16) begin : g_lvl_chk
    $error("cmpctl_top: LEVEL_W must be 1 to 16");
  end
  // a reference wider than the level code would be cut silently
  if ((BANDGAP_LEVEL >> LEVEL_W) != 16'h0000) begin : g_bg_chk
    $error("cmpctl_top: BANDGAP_LEVEL must fit in LEVEL_W bits");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // register fields live in packed carriers; outputs come from flops
  cmpctl_pkg::cmpct_ctrl_t ctrl_ff, nxt_ctrl;
  cmpctl_pkg::cmpct_conv_t conv_ff, nxt_conv;
  logic              flag_ff, nxt_flag;
  logic              sync1_ff, sync2_ff, prev_ff;
  logic              irq_ff, nxt_irq;
  logic              cap_ff, nxt_cap;
  logic [1:0]        pin1_ff, pin2_ff;
  logic [1:0]        pin_rd_ff, nxt_pin_rd;
  logic              ack_ff, nxt_ack;
  logic [31:0]       dat_ff, nxt_dat;

  // ----------------------------------------------------------------
  // analog input selection and compare
  // ----------------------------------------------------------------
  logic [LEVEL_W-1:0] chan_level [NUM_CHAN];
  logic [LEVEL_W-1:0] neg_level;
  logic [LEVEL_W-1:0] pos_level;
  logic               use_mux;
  logic               cmp_raw;

  // level codes stand in for voltages; the compare models the core
  // unpack converter inputs into one level per channel
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    assign chan_level[g] = converter_input_pins_i[g*LEVEL_W +: LEVEL_W];
  end

  // converter running owns the multiplexer, so fall back to the pin
  assign use_mux = conv_ff.neg_input_mux_enable & ~conv_ff.converter_enable;
  assign neg_level = use_mux ? chan_level[conv_ff.channel_select] : negative_pin_i;
  assign pos_level = ctrl_ff.bandgap_positive_select ? BANDGAP_LEVEL[LEVEL_W-1:0]
                                                     : positive_pin_i;
  // powered-down comparator reads as low; this stands for the core
  assign cmp_raw = ~ctrl_ff.power_off & (pos_level > neg_level);

  // ----------------------------------------------------------------
  // synchronisers and edge history
  // ----------------------------------------------------------------
  // first stage feeds only the second; edge logic looks at sync2 only
  // the extra edge of latency is the price of a clean status bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
      pin1_ff  <= 2'h0;
      pin2_ff  <= 2'h0;
    end else begin
      sync1_ff <= cmp_raw;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      pin1_ff  <= pin_digital_i;
      pin2_ff  <= pin1_ff;
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // prev resets to the idle low level of the result, so no false
  // edge appears in the first cycles after reset
  logic rise_ev, fall_ev, sel_ev;

  assign rise_ev = sync2_ff & ~prev_ff;
  assign fall_ev = ~sync2_ff & prev_ff;

  // toggle takes both edges; a rise and a fall never share a cycle
  // reserved mode raises nothing
  always_comb begin
    case (ctrl_ff.mode)
      cmpctl_pkg::CMPCT_MODE_TOGGLE: sel_ev = rise_ev | fall_ev;
      cmpctl_pkg::CMPCT_MODE_FALL:   sel_ev = fall_ev;
      cmpctl_pkg::CMPCT_MODE_RISE:   sel_ev = rise_ev;
      default:                       sel_ev = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  logic       req;
  logic       wr_lane;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // classic single cycle: no burst tags, no error or retry answer;
  // every address is acknowledged so a stray access cannot hang
  assign req     = wb_cyc_i & wb_stb_i;
  // write lands at the edge where ack is seen high by the master
  assign wr_lane = req & wb_we_i & ack_ff & wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  // read mux; unmapped addresses answer with zero
  // unimplemented bits of mapped registers read as zero too, so
  // software can probe which controls this build carries;
  // the result bit is captured at the request edge, not live at ack
  always_comb begin
    rbyte = cmpctl_pkg::RST_BYTE;
    case (wb_adr_i)
      cmpctl_pkg::ADDR_CMP_CS: begin
        rbyte[cmpctl_pkg::POS_POWER_OFF]  = ctrl_ff.power_off;
        rbyte[cmpctl_pkg::POS_BANDGAP]    = ctrl_ff.bandgap_positive_select;
        rbyte[cmpctl_pkg::POS_RESULT]     = sync2_ff;
        rbyte[cmpctl_pkg::POS_IRQ_FLAG]   = flag_ff;
        rbyte[cmpctl_pkg::POS_IRQ_ENABLE] = ctrl_ff.cmp_irq_enable;
        rbyte[cmpctl_pkg::POS_CAPTURE]    = ctrl_ff.cmp_capture_route;
        rbyte[cmpctl_pkg::POS_MODE_HI]    = ctrl_ff.mode[1];
        rbyte[cmpctl_pkg::POS_MODE_LO]    = ctrl_ff.mode[0];
      end
      cmpctl_pkg::ADDR_CONV_CSB: begin
        rbyte[cmpctl_pkg::POS_MUX_ENABLE] = conv_ff.neg_input_mux_enable;
      end
      cmpctl_pkg::ADDR_DIG_DIS: begin
        rbyte[cmpctl_pkg::POS_NEG_BUF_OFF] = conv_ff.negative_pin_buffer_off;
        rbyte[cmpctl_pkg::POS_POS_BUF_OFF] = conv_ff.positive_pin_buffer_off;
      end
      cmpctl_pkg::ADDR_CONV_CSA: begin
        rbyte[cmpctl_pkg::POS_CONV_ENABLE] = conv_ff.converter_enable;
      end
      cmpctl_pkg::ADDR_CONV_CH: begin
        rbyte[cmpctl_pkg::CHAN_W-1:0] = conv_ff.channel_select;
      end
      default: rbyte = cmpctl_pkg::RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_conv = conv_ff;
    nxt_flag = flag_ff;
    // one wait state: ack rises the cycle after the request, then drops
    nxt_ack  = req & ~ack_ff;
    nxt_dat  = ack_ff ? dat_ff : {24'h000000, rbyte};
    if (wr_lane) begin
      case (wb_adr_i)
        cmpctl_pkg::ADDR_CMP_CS: begin
          // mode changes with enable set never fire; only a synced edge sets the flag
          nxt_ctrl.power_off               = wbyte[cmpctl_pkg::POS_POWER_OFF];
          nxt_ctrl.bandgap_positive_select = wbyte[cmpctl_pkg::POS_BANDGAP];
          nxt_ctrl.cmp_irq_enable          = wbyte[cmpctl_pkg::POS_IRQ_ENABLE];
          nxt_ctrl.cmp_capture_route       = wbyte[cmpctl_pkg::POS_CAPTURE];
          nxt_ctrl.mode = cmpctl_pkg::cmpct_mode_t'({wbyte[cmpctl_pkg::POS_MODE_HI],
                                                     wbyte[cmpctl_pkg::POS_MODE_LO]});
          if (wbyte[cmpctl_pkg::POS_IRQ_FLAG]) begin
            nxt_flag = 1'b0;
          end
        end
        cmpctl_pkg::ADDR_CONV_CSB: begin
          // mux request only; the converter state still gates it
          nxt_conv.neg_input_mux_enable = wbyte[cmpctl_pkg::POS_MUX_ENABLE];
        end
        cmpctl_pkg::ADDR_DIG_DIS: begin
          // buffer-off takes hold at once; pin reads mask at the same edge
          nxt_conv.negative_pin_buffer_off = wbyte[cmpctl_pkg::POS_NEG_BUF_OFF];
          nxt_conv.positive_pin_buffer_off = wbyte[cmpctl_pkg::POS_POS_BUF_OFF];
        end
        cmpctl_pkg::ADDR_CONV_CSA: begin
          // converter on reclaims the multiplexer from the comparator
          nxt_conv.converter_enable = wbyte[cmpctl_pkg::POS_CONV_ENABLE];
        end
        cmpctl_pkg::ADDR_CONV_CH: begin
          // a channel change may raise an event; software masks it
          nxt_conv.channel_select = wbyte[cmpctl_pkg::CHAN_W-1:0];
        end
        // writes to unmapped places are dropped without an error
        default: nxt_flag = flag_ff;
      endcase
    end
    // vector taken is a one-cycle pulse from the interrupt controller
    if (irq_vector_taken_i) begin
      nxt_flag = 1'b0;
    end
    // an event in the clearing cycle must not be lost: set wins
    if (sel_ev) begin
      nxt_flag = 1'b1;
    end
    // outputs follow the new state so each comes from a flip-flop
    nxt_irq    = nxt_flag & nxt_ctrl.cmp_irq_enable & global_irq_enable_i;
    // capture sees the synced result, never the raw compare
    nxt_cap    = nxt_ctrl.cmp_capture_route & sync2_ff;
    nxt_pin_rd = pin2_ff & ~{nxt_conv.negative_pin_buffer_off,
                             nxt_conv.positive_pin_buffer_off};
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // mode resets to toggle, code zero, like every other field
      ctrl_ff   <= '{power_off: 1'b0, bandgap_positive_select: 1'b0,
                     cmp_irq_enable: 1'b0, cmp_capture_route: 1'b0,
                     mode: cmpctl_pkg::CMPCT_MODE_TOGGLE};
      conv_ff   <= '0;
      flag_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      cap_ff    <= 1'b0;
      pin_rd_ff <= 2'h0;
      ack_ff    <= 1'b0;
      dat_ff    <= 32'h00000000;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      conv_ff   <= nxt_conv;
      flag_ff   <= nxt_flag;
      irq_ff    <= nxt_irq;
      cap_ff    <= nxt_cap;
      pin_rd_ff <= nxt_pin_rd;
      ack_ff    <= nxt_ack;
      dat_ff    <= nxt_dat;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a register bit or a registered product, so the
  // timer and interrupt controller never see a combinational glitch
  assign wb_ack_o         = ack_ff;
  assign wb_dat_o         = dat_ff;
  assign cmp_irq_req_o    = irq_ff;
  assign capture_input_o  = cap_ff;
  assign cmp_power_off_o  = ctrl_ff.power_off;
  assign pin_buffer_off_o = {conv_ff.negative_pin_buffer_off,
                             conv_ff.positive_pin_buffer_off};
  assign pin_read_o       = pin_rd_ff;
endmodule : cmpctl_top
`default_nettype wire
